/* rtl/adcsq_pkg.sv */
// adcsq_pkg: constants, types and decode helpers of the converter sequencer.
// assumes an 8-bit register port and a 10 MHz system clock, one state per cycle.
package adcsq_pkg;
  // register port and result widths, channel count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W  = 10;
  localparam int CH_N   = 8;

  // register offsets
  localparam logic [7:0] CSR_OFFS  = 8'he8;
  localparam logic [7:0] TRIG_OFFS = 8'he9;
  localparam logic [7:0] STAT_OFFS = 8'hea;
  localparam logic [7:0] MASK_OFFS = 8'heb;
  localparam logic [3:0] RES_PAGE  = 4'hd;  // results at 0xd0..0xdf, two bytes each

  // control/status field positions
  localparam int END_BIT  = 7;
  localparam int IE_BIT   = 6;
  localparam int ST_BIT   = 5;
  localparam int SCAN_BIT = 4;
  localparam int SPD_BIT  = 3;
  localparam int EXT_TRIGGER_ENABLE_BIT = 7;

  // values after reset
  localparam logic [7:0] CSR_RESET     = 8'h00;
  localparam logic [6:0] TRIG_RSVD     = 7'h7f;  // reserved bits read as one
  localparam logic [2:0] EV_RESET      = 3'h0;

  // event bits of the sticky status register
  localparam int EV_END  = 0;
  localparam int EV_CONV = 1;
  localparam int EV_TRIG = 2;

  // conversion time, in states, and in clock cycles
  localparam int STATE_NS    = 100;
  localparam int CLK_NS      = 100;
  localparam int SLOW_STATES = 266;
  localparam int FAST_STATES = 134;
  localparam int SLOW_CYC    = (SLOW_STATES * STATE_NS) / CLK_NS;  // longest: rounds down
  localparam int FAST_CYC    = (FAST_STATES * STATE_NS) / CLK_NS;
  localparam int CNT_W       = 9;
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_CYC - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_CYC - 1);

  typedef enum logic {ADCSQ_IDLE, ADCSQ_CONVERT} adcsq_state_e;

  // true when an address lands in the result page
  function automatic logic adcsq_res_hit(input logic [7:0] addr);
    return addr[7:4] == RES_PAGE;
  endfunction
endpackage

/* rtl/adcsq_result_mem.sv */
// adcsq_result_mem: eight 10-bit conversion results plus the read-data register.
// assumes the top hands in the byte of its own registers for every other address.
`timescale 1ns/100ps
`default_nettype none
module adcsq_result_mem
  import adcsq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              we_in,
  input  wire logic [2:0]        wr_ch_in,
  input  wire logic [RES_W-1:0]  wr_data_in,
  input  wire logic              rd_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] reg_byte_in,
  output logic      [DATA_W-1:0] rdata_out
);
  typedef struct packed {
    logic [CH_N-1:0][RES_W-1:0] words;
    logic [DATA_W-1:0]          rdata;
  } adcsq_mem_s;

  adcsq_mem_s q;
  adcsq_mem_s d;

  // even byte holds the upper eight bits, odd byte the lower two left-aligned
  always_comb begin
    d = q;
    d.rdata = '0;  // read data stand for one cycle only
    if (we_in) begin
      d.words[wr_ch_in] = wr_data_in;
    end
    if (rd_in) begin
      if (adcsq_res_hit(addr_in)) begin
        if (addr_in[0]) begin
          d.rdata = {q.words[addr_in[3:1]][1:0], 6'h00};
        end else begin
          d.rdata = q.words[addr_in[3:1]][9:2];
        end
      end else begin
        d.rdata = reg_byte_in;
      end
    end
  end

  // results keep no reset value beyond zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_out = q.rdata;
endmodule // adcsq_result_mem
`default_nettype wire

/* rtl/adcsq_top.sv */
// adcsq_top: control and sequencing of an eight-input converter.
// assumes a conversion core that samples while sample_out is high and
// presents a settled result on conv_data_in in the last cycle of the window.
`timescale 1ns/100ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              ext_trigger_pin_in,
  input  wire logic [RES_W-1:0]  conv_data_in,
  output logic      [2:0]        analog_input_n_out,
  output logic                   sample_out,
  output logic                   conv_done_irq_out
);
  typedef struct packed {
    adcsq_state_e     st;
    logic             conv_end_flag;
    logic             end_irq_enable;
    logic             conv_start_bit;
    logic             scan_mode;
    logic             conv_speed_select;
    logic [2:0]       chan_sel;         // group select, channel hi, channel lo
    logic             ext_trigger_enable;
    logic             flag_seen;        // end flag was read as one
    logic [CNT_W-1:0] cnt;
    logic [2:0]       cur_ch;
    logic [2:0]       ev_stat;
    logic [2:0]       ev_mask;
    logic             irq;
    logic             trig_prev;
    logic             sample;
  } adcsq_top_s;

  localparam adcsq_top_s RESET_S = '{
    st:                 ADCSQ_IDLE,
    conv_end_flag:      CSR_RESET[END_BIT],
    end_irq_enable:     CSR_RESET[IE_BIT],
    conv_start_bit:     CSR_RESET[ST_BIT],
    scan_mode:          CSR_RESET[SCAN_BIT],
    conv_speed_select:  CSR_RESET[SPD_BIT],
    chan_sel:           CSR_RESET[2:0],
    ev_stat:            EV_RESET,
    ev_mask:            EV_RESET,
    default:            '0
  };

  adcsq_top_s       q;
  adcsq_top_s       d;
  logic             res_we;
  logic             trig_edge;
  logic [2:0]       ev;
  logic [DATA_W-1:0] reg_byte;

  // last count of a conversion window for the chosen speed
  function automatic logic [CNT_W-1:0] conv_last(input logic fast);
    return fast ? FAST_LAST : SLOW_LAST;
  endfunction

  // byte of the small registers, handed to the read-data flop
  always_comb begin
    reg_byte = '0;  // unmapped addresses read zero
    unique case (addr_in)
      CSR_OFFS:  reg_byte = {q.conv_end_flag, q.end_irq_enable, q.conv_start_bit,
                             q.scan_mode, q.conv_speed_select, q.chan_sel};
      TRIG_OFFS: reg_byte = {q.ext_trigger_enable, TRIG_RSVD};
      STAT_OFFS: reg_byte = {5'h00, q.ev_stat};
      MASK_OFFS: reg_byte = {5'h00, q.ev_mask};
      default:   reg_byte = '0;
    endcase
  end

  // next state: software writes first, hardware sets after so sets win
  always_comb begin
    d         = q;
    res_we    = 1'b0;
    ev        = '0;
    trig_edge = q.ext_trigger_enable & ext_trigger_pin_in & ~q.trig_prev;
    d.trig_prev = ext_trigger_pin_in;

    // register writes
    if (wr_in) begin
      unique case (addr_in)
        CSR_OFFS: begin
          d.end_irq_enable    = wdata_in[IE_BIT];
          d.conv_start_bit    = wdata_in[ST_BIT];
          d.scan_mode         = wdata_in[SCAN_BIT];
          d.conv_speed_select = wdata_in[SPD_BIT];
          d.chan_sel          = wdata_in[2:0];
          // only a zero after a read of one clears; a one never sets
          if (!wdata_in[END_BIT] && q.flag_seen) begin
            d.conv_end_flag = 1'b0;
          end
          d.flag_seen = 1'b0;
        end
        TRIG_OFFS: d.ext_trigger_enable = wdata_in[EXT_TRIGGER_ENABLE_BIT];
        MASK_OFFS: d.ev_mask = wdata_in[2:0];
        default: ;
      endcase
    end

    // register reads with side effects
    if (rd_in && addr_in == CSR_OFFS && q.conv_end_flag) begin
      d.flag_seen = 1'b1;
    end
    if (rd_in && addr_in == STAT_OFFS) begin
      d.ev_stat = '0;
    end

    // conversion sequencer
    unique case (q.st)
      ADCSQ_IDLE: begin
        d.sample = 1'b0;
        if (q.conv_start_bit) begin
          d.st     = ADCSQ_CONVERT;
          d.cnt    = '0;
          d.sample = 1'b1;
          // scan starts at the group's first input
          d.cur_ch = q.scan_mode ? {q.chan_sel[2], 2'b00} : q.chan_sel;
        end
      end
      ADCSQ_CONVERT: begin
        if (!q.conv_start_bit) begin
          // abandoned conversion leaves no result and no flag
          d.st     = ADCSQ_IDLE;
          d.sample = 1'b0;
        end else if (q.cnt == conv_last(q.conv_speed_select)) begin
          res_we      = 1'b1;
          ev[EV_CONV] = 1'b1;
          d.cnt       = '0;
          if (!q.scan_mode) begin
            d.conv_start_bit = 1'b0;
            d.conv_end_flag  = 1'b1;
            ev[EV_END]       = 1'b1;
            d.st             = ADCSQ_IDLE;
            d.sample         = 1'b0;
          end else if (q.cur_ch[1:0] >= q.chan_sel[1:0]) begin
            // pass finished: flag it and wrap to the group's first input
            d.conv_end_flag = 1'b1;
            ev[EV_END]      = 1'b1;
            d.cur_ch        = {q.chan_sel[2], 2'b00};
          end else begin
            d.cur_ch = q.cur_ch + 3'h1;
          end
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
    endcase

    // a trigger edge beats a same-cycle software clear of the start bit
    if (trig_edge) begin
      d.conv_start_bit = 1'b1;
      ev[EV_TRIG]      = 1'b1;
    end

    d.ev_stat = d.ev_stat | ev;
    // request from the end flag, plus any unmasked sticky event
    d.irq = (d.conv_end_flag & d.end_irq_enable) | (|(d.ev_stat & d.ev_mask));
  end

  // one register for the whole state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= RESET_S;
    end else begin
      q <= d;
    end
  end

  // results and the read-data register
  adcsq_result_mem u_mem (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .we_in       (res_we),
    .wr_ch_in    (q.cur_ch),
    .wr_data_in  (conv_data_in),
    .rd_in       (rd_in),
    .addr_in     (addr_in),
    .reg_byte_in (reg_byte),
    .rdata_out   (rdata_out)
  );

  assign analog_input_n_out = q.cur_ch;
  assign sample_out         = q.sample;
  assign conv_done_irq_out  = q.irq;

  // checks on the sequencer and flag handling
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  conv_length_a: assert property (res_we |-> q.cnt == conv_last(q.conv_speed_select)
                                  && q.sample)
    else $error("conversion window length wrong");

  single_self_clear_a: assert property (res_we && !q.scan_mode && !trig_edge
                                        |=> !q.conv_start_bit && !sample_out)
    else $error("start bit not cleared after single conversion");

  scan_continue_a: assert property (res_we && q.scan_mode && !wr_in
                                    |=> q.conv_start_bit && sample_out)
    else $error("scan stopped without a zero write");

  single_flag_a: assert property (res_we && !q.scan_mode |=> q.conv_end_flag)
    else $error("end flag not set after single conversion");

  scan_flag_a: assert property (res_we && q.scan_mode && !q.conv_end_flag
                                && q.cur_ch[1:0] < q.chan_sel[1:0]
                                |=> !q.conv_end_flag)
    else $error("end flag set before pass finished");

  flag_hold_a: assert property (q.conv_end_flag && !q.flag_seen |=> q.conv_end_flag)
    else $error("end flag cleared without a prior read");

  flag_no_set_a: assert property (!q.conv_end_flag && !res_we |=> !q.conv_end_flag)
    else $error("end flag set by software");

  irq_follow_a: assert property (q.ev_mask == '0 && !(wr_in && addr_in == MASK_OFFS)
                                 |=> conv_done_irq_out == (q.conv_end_flag
                                 && q.end_irq_enable))
    else $error("request does not follow flag and enable");

  idle_hold_a: assert property (!q.conv_start_bit ##1 !q.conv_start_bit
                                |=> !sample_out)
    else $error("converter active while start bit is zero");

  trig_ignore_a: assert property (!q.ext_trigger_enable && !wr_in && !q.conv_start_bit
                                  |=> !q.conv_start_bit)
    else $error("trigger acted while disabled");

  group_keep_a: assert property (sample_out && q.scan_mode
                                 |-> q.cur_ch[2] == q.chan_sel[2] || $past(wr_in)
                                 || !$past(sample_out) || $past(q.scan_mode) == 1'b0)
    else $error("scan left the selected group");

  single_cov_c: cover property (res_we && !q.scan_mode);
  scan_pass_c:  cover property (res_we && q.scan_mode && q.cur_ch[1:0] == 2'h3);
  trig_start_c: cover property (trig_edge && !q.conv_start_bit);
  flag_clear_c: cover property (q.conv_end_flag ##1 !q.conv_end_flag);
endmodule // adcsq_top
`default_nettype wire

/* sim/adcsq_core_model.sv */
// adcsq_core_model: behavioural conversion core behind the sequencer.
// assumes sample_in marks the window; the value settles SETTLE cycles after the mux moves.
`timescale 1ns/100ps
`default_nettype none
module adcsq_core_model #(
  parameter int SETTLE = 4
) (
  input  wire logic       clk_in,
  input  wire logic       sample_in,
  input  wire logic [2:0] chan_in,
  input  wire logic [9:0] base_in,
  output logic      [9:0] conv_data_out
);
  logic [2:0] last_ch_q = 3'h0;
  logic [7:0] age_q     = 8'h00;
  logic [9:0] noise_q   = 10'h2a5;

  // age restarts on a new channel; noise flips each cycle so an early sample never matches
  always_ff @(posedge clk_in) begin
    last_ch_q <= chan_in;
    noise_q   <= ~noise_q;
    if (!sample_in || chan_in != last_ch_q) begin
      age_q <= 8'h00;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end

  // each input has its own value, so a wrong mux setting shows in the result
  assign conv_data_out = (sample_in && age_q >= 8'(SETTLE)) ?
                         (base_in ^ {chan_in, chan_in, chan_in, 1'b0}) : noise_q;
endmodule // adcsq_core_model
`default_nettype wire

/* sim/testbench.sv */
// testbench: register-port and trigger tests of the converter sequencer.
// assumes the core model on the conversion side; reads are compared a cycle late.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import adcsq_pkg::*;
;
  logic       clk_in   = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [7:0] addr     = 8'h00;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic       trig     = 1'b0;
  logic [9:0] base     = 10'h000;
  logic       pend     = 1'b0;
  logic [7:0] rdata;
  logic [9:0] cdata;
  logic [2:0] chan;
  logic       sample;
  logic       irq;
  logic [8:0] notes[$];
  int         num_errors = 0;
  int         checks     = 0;

  always #50 clk_in = ~clk_in;

  adcsq_top i_adcsq_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_trigger_pin_in(trig),
    .conv_data_in(cdata), .analog_input_n_out(chan), .sample_out(sample),
    .conv_done_irq_out(irq));
  // slow settling: the result is ready only late in a fast window
  adcsq_core_model #(.SETTLE(100)) i_adcsq_core_model (
    .clk_in(clk_in), .sample_in(sample), .chan_in(chan), .base_in(base),
    .conv_data_out(cdata));

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    report(32'(got), 32'(exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    report(32'(got), 32'(exp));
  endtask
  task automatic cmp_ch(input logic [2:0] got, input logic [2:0] exp);
    report(32'(got), 32'(exp));
  endtask
  task automatic cmp_len(input int got, input int exp);
    report(got, exp);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // bit 8 of a note asks for a compare
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    notes.push_back({1'b1, exp});
    @(posedge clk_in);
    rd <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  always @(negedge clk_in) begin : read_watch
    logic [8:0] n;
    if (pend && notes.size() > 0) begin
      n = notes.pop_front();
      if (n[8]) cmp_rd(rdata, n[7:0]);
    end
    pend = rd;
  end

  task automatic wait_sample(input logic lvl);
    int n;
    n = 0;
    // start on a falling edge: sample_out may be changing at the rising edge we came from
    @(negedge clk_in);
    while (sample !== lvl && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (sample !== lvl) cmp_bit(sample, lvl);
  endtask
  task automatic window(output int len, output logic [2:0] seen);
    wait_sample(1'b1);
    seen = chan;
    len  = 0;
    while (sample === 1'b1 && len < 400) begin
      @(negedge clk_in);
      len++;
    end
  endtask
  task automatic pulse_trig;
    @(posedge clk_in);
    trig <= 1'b1;
    repeat (2) @(posedge clk_in);
    trig <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // the tests need about 3000 cycles; over six times that means a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    wrap_up;
  end

  initial begin
    int         len;
    logic [2:0] seen;
    logic       ie;
    logic [7:0] csr;
    logic [9:0] exp;
    void'($urandom(29));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_reg(CSR_OFFS, CSR_RESET);
    rd_reg(TRIG_OFFS, {1'b0, TRIG_RSVD});
    rd_reg(MASK_OFFS, 8'h00);
    rd_reg(8'h10, 8'h00);
    $display("test reset done");
    // one conversion per channel, speeds alternating, enable random
    for (int ch = 0; ch < CH_N; ch++) begin
      ie   = 1'($urandom);
      base <= 10'($urandom);
      csr  = {1'b0, ie, 1'b1, 1'b0, 1'(ch), 3'(ch)};
      wr_reg(CSR_OFFS, csr);
      window(len, seen);
      cmp_len(len, ch[0] ? FAST_CYC : SLOW_CYC);
      cmp_ch(seen, 3'(ch));
      repeat (2) @(negedge clk_in);
      cmp_bit(irq, ie);
      exp = base ^ {3'(ch), 3'(ch), 3'(ch), 1'b0};
      rd_reg(8'hd0 + 8'(2 * ch), exp[9:2]);
      rd_reg(8'hd1 + 8'(2 * ch), {exp[1:0], 6'h00});
      csr[ST_BIT] = 1'b0;
      wr_reg(CSR_OFFS, csr);
      rd_reg(CSR_OFFS, csr | 8'h80);
      wr_reg(CSR_OFFS, csr | 8'h80);
      rd_reg(CSR_OFFS, csr | 8'h80);
      wr_reg(CSR_OFFS, csr);
      rd_reg(CSR_OFFS, csr);
      repeat (2) @(negedge clk_in);
      cmp_bit(irq, 1'b0);
    end
    $display("test single done");
    // scan over inputs 4 to 6 at fast speed, then stopped mid-window
    wr_reg(CSR_OFFS, 8'h3e);
    wait_sample(1'b1);
    for (int i = 0; i < 4; i++) begin
      cmp_ch(chan, 3'(4 + i % 3));
      if (i == 1) begin
        rd_reg(CSR_OFFS, 8'h3e);
        repeat (FAST_CYC - 1) @(negedge clk_in);
      end else begin
        repeat (FAST_CYC) @(negedge clk_in);
      end
    end
    rd_reg(CSR_OFFS, 8'hbe);
    wr_reg(CSR_OFFS, 8'h9e);
    repeat (3) @(negedge clk_in);
    cmp_bit(sample, 1'b0);
    repeat (300) @(negedge clk_in);
    cmp_bit(sample, 1'b0);
    exp = base ^ {3'd6, 3'd6, 3'd6, 1'b0};
    rd_reg(8'hdc, exp[9:2]);
    rd_reg(CSR_OFFS, 8'h9e);
    $display("test scan done");
    // trigger pin start with events unmasked, then with the pin disabled
    wr_reg(CSR_OFFS, 8'h0a);
    rd_reg(STAT_OFFS, 8'h03);
    rd_reg(STAT_OFFS, 8'h00);
    wr_reg(MASK_OFFS, 8'h07);
    wr_reg(TRIG_OFFS, 8'h80);
    rd_reg(TRIG_OFFS, 8'hff);
    @(negedge clk_in);
    cmp_bit(irq, 1'b0);
    pulse_trig;
    window(len, seen);
    cmp_ch(seen, 3'd2);
    repeat (2) @(negedge clk_in);
    cmp_bit(irq, 1'b1);
    rd_reg(CSR_OFFS, 8'h8a);
    rd_reg(STAT_OFFS, 8'h07);
    repeat (3) @(negedge clk_in);
    cmp_bit(irq, 1'b0);
    wr_reg(TRIG_OFFS, 8'h00);
    rd_reg(TRIG_OFFS, 8'h7f);
    pulse_trig;
    repeat (20) @(negedge clk_in);
    cmp_bit(sample, 1'b0);
    $display("test trigger done");
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
